// File: include/ptps_pkg.sv
// Constants shared by the one-step stamp rewriter.
package ptps_pkg;
  localparam logic [7:0]  REG_CTRL    = 8'h00;
  localparam logic [7:0]  REG_RX_LAT  = 8'h04;
  localparam logic [7:0]  REG_TX_LAT  = 8'h08;
  localparam logic [7:0]  REG_ASYM    = 8'h0C;
  localparam logic [7:0]  REG_ID_OFF  = 8'h10;
  localparam logic [7:0]  REG_QSTAT   = 8'h14;
  localparam logic [7:0]  REG_QDATA   = 8'h20;
  localparam logic [7:0]  REG_QLAST   = 8'h38;
  localparam int          CTRL_RXEN   = 8;
  localparam int          CTRL_TXEN   = 9;
  localparam int          CTRL_TC     = 10;
  localparam int          QST_POP     = 0;
  localparam int          QST_OVF     = 8;
  localparam logic [10:0] RST_CTRL    = 11'h000;
  localparam logic [15:0] ET_PTP      = 16'h88F7;
  localparam logic [15:0] ET_IP4      = 16'h0800;
  localparam logic [15:0] ET_IP6      = 16'h86DD;
  localparam logic [7:0]  PROTO_UDP   = 8'h11;
  localparam int          LA_ET       = 12;
  localparam int          LA_IP4_PROT = 23;
  localparam int          LA_IP6_NH   = 20;
  localparam logic [6:0]  BASE_L2     = 7'd14;
  localparam logic [6:0]  BASE_IP4    = 7'd42;
  localparam logic [6:0]  BASE_IP6    = 7'd62;
  localparam logic [10:0] POS_UDP_CS  = 11'd40;
  localparam logic [10:0] OFF_CORR    = 11'd8;
  localparam logic [10:0] LEN_CORR    = 11'd8;
  localparam logic [10:0] OFF_RESV    = 11'd16;
  localparam logic [10:0] LEN_RESV    = 11'd4;
  localparam logic [10:0] OFF_ORIG    = 11'd34;
  localparam logic [10:0] LEN_ORIG    = 11'd10;
  localparam logic [10:0] ID_BYTES    = 11'd16;
  localparam logic [3:0]  MSG_SYNC    = 4'h0;
  localparam logic [3:0]  MSG_DREQ    = 4'h1;
  localparam logic [30:0] NS_PER_SEC  = 31'd1000000000;
  localparam logic [31:0] CRC_POLY    = 32'hEDB88320;
  localparam logic [31:0] CRC_INIT    = 32'hFFFFFFFF;
  localparam int          MIN_DLY     = 24;
  localparam int          QDATA_WORDS = 7;
  typedef enum logic [1:0] {
    KIND_NONE, KIND_L2, KIND_IP4, KIND_IP6
  } ptps_kind_e;
endpackage : ptps_pkg

// File: design/ptps_rewriter.sv
// Per-port one-step stamp rewriter with its register file and stamp queue.
////////////////////////////////////////////////////////////////////////////
// Contract
// - Each receive start of frame latches the time-of-day counter for it.
// - Ingress latency offset is subtracted from the latched receive stamp.
// - A programmable asymmetry adjusts correction fields by frame type.
// - Receive bytes pass a short delay line; analysis reads a copy.
// - Matched receive Sync or Delay_req writes the 4 spare header bytes.
// - Unmatched frames pass unchanged and their latched stamp is dropped.
// - Receive write puts stamp nanoseconds in spare bytes, recomputes FCS.
// - Rewriter drains the delay line, counts bytes, overwrites positions.
// - Original FCS checked; bad input FCS leaves as inverted new FCS.
// - Modified IPv4 frames get their UDP checksum set to zero.
// - Modified IPv6 frames get trailing compensation bytes adjusted.
// - Receive: stamp minus offset in spare bytes; Sync adds asymmetry.
// - Transmit bytes are likewise delayed and classified by an analyzer.
// - Matched transmit Sync writes the 10-byte origin stamp field.
// - Transmit Delay_req writes and saves, with 16 chosen identifier bytes.
// - Stamp queue stores stamp plus identifier pairs for host reads.
// - Transmit: origin is stamp plus offset; Delay_req adds asymmetry.
// - Transit mode writes actual minus software send time to Delay_req correction.
// - Delay_resp and other messages pass unmodified as plain traffic.
// - Decryption sits before this unit; only cleartext is classified.
module ptps_rewriter #(
  parameter int DLY    = 24,
  parameter int QDEPTH = 8
) (
  input  wire logic        clock,
  input  wire logic        resetn,
  input  wire logic [47:0] timeSec,
  input  wire logic [29:0] timeNs,
  input  wire logic [7:0]  lineRxData,
  input  wire logic        lineRxValid,
  input  wire logic        lineRxLast,
  output logic      [7:0]  sysRxData,
  output logic             sysRxValid,
  output logic             sysRxLast,
  input  wire logic [7:0]  sysTxData,
  input  wire logic        sysTxValid,
  input  wire logic        sysTxLast,
  output logic      [7:0]  lineTxData,
  output logic             lineTxValid,
  output logic             lineTxLast,
  input  wire logic [7:0]  regAddr,
  input  wire logic [31:0] regWdata,
  input  wire logic        regWr,
  input  wire logic        regRd,
  output logic      [31:0] regRdata
);
  localparam int QW = $clog2(QDEPTH);
  if (QDEPTH < 2 || (1 << QW) != QDEPTH) begin : g_bad_q
    $error("QDEPTH must be a power of two of at least two.");
  end

  logic [10:0]   ctrl_r;
  logic [29:0]   rxLat_r;
  logic [29:0]   txLat_r;
  logic [31:0]   asym_r;
  logic [5:0]    idOff_r;
  logic          ovf_r;
  logic [47:0]   qSec [QDEPTH];
  logic [29:0]   qNs [QDEPTH];
  logic [127:0]  qId [QDEPTH];
  logic [QW-1:0] wrPtr_r;
  logic [QW-1:0] rdPtr_r;
  logic [QW:0]   level_r;
  logic          txSave;
  logic [47:0]   txSaveSec;
  logic [29:0]   txSaveNs;
  logic [127:0]  txSaveId;
  logic          push;
  logic          pop;
  logic          full;
  logic [31:0]   qWord;
  logic [7:0]    qIdx;

  //////////////////////////////////////////////////////////////////////////
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      ctrl_r  <= ptps_pkg::RST_CTRL;
      rxLat_r <= '0;
      txLat_r <= '0;
      asym_r  <= '0;
      idOff_r <= '0;
    end else if (regWr) begin
      case (regAddr)
        ptps_pkg::REG_CTRL:   ctrl_r  <= regWdata[10:0];
        ptps_pkg::REG_RX_LAT: rxLat_r <= regWdata[29:0];
        ptps_pkg::REG_TX_LAT: txLat_r <= regWdata[29:0];
        ptps_pkg::REG_ASYM:   asym_r  <= regWdata;
        ptps_pkg::REG_ID_OFF: idOff_r <= regWdata[5:0];
        default: ;
      endcase
    end
  end

  // A full queue drops the new pair, keeping the oldest unread.
  assign full = level_r == (QW + 1)'(QDEPTH);
  assign push = txSave && !full;
  assign pop  = regWr && regAddr == ptps_pkg::REG_QSTAT
                && regWdata[ptps_pkg::QST_POP] && level_r != '0;

  always_ff @(posedge clock) begin
    if (push) begin
      qSec[wrPtr_r] <= txSaveSec;
      qNs[wrPtr_r]  <= txSaveNs;
      qId[wrPtr_r]  <= txSaveId;
    end
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      wrPtr_r <= '0;
      rdPtr_r <= '0;
      level_r <= '0;
    end else begin
      wrPtr_r <= wrPtr_r + QW'(push);
      rdPtr_r <= rdPtr_r + QW'(pop);
      level_r <= level_r + (QW + 1)'(push) - (QW + 1)'(pop);
    end
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      ovf_r <= 1'b0;
    end else if (txSave && full) begin
      ovf_r <= 1'b1;
    end else if (regWr && regAddr == ptps_pkg::REG_QSTAT
                 && regWdata[ptps_pkg::QST_OVF]) begin
      ovf_r <= 1'b0;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  assign qIdx = (regAddr - ptps_pkg::REG_QDATA) >> 2;

  always_comb begin
    case (qIdx)
      8'h00:   qWord = {2'h0, qNs[rdPtr_r]};
      8'h01:   qWord = qSec[rdPtr_r][31:0];
      8'h02:   qWord = {16'h0000, qSec[rdPtr_r][47:32]};
      8'h03:   qWord = qId[rdPtr_r][127:96];
      8'h04:   qWord = qId[rdPtr_r][95:64];
      8'h05:   qWord = qId[rdPtr_r][63:32];
      8'h06:   qWord = qId[rdPtr_r][31:0];
      default: qWord = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      regRdata <= '0;
    end else if (regRd) begin
      case (regAddr)
        ptps_pkg::REG_CTRL:   regRdata <= {21'h0, ctrl_r};
        ptps_pkg::REG_RX_LAT: regRdata <= {2'h0, rxLat_r};
        ptps_pkg::REG_TX_LAT: regRdata <= {2'h0, txLat_r};
        ptps_pkg::REG_ASYM:   regRdata <= asym_r;
        ptps_pkg::REG_ID_OFF: regRdata <= {26'h0, idOff_r};
        ptps_pkg::REG_QSTAT:
          regRdata <= {23'h0, ovf_r, 8'(level_r)};
        default: begin
          if (regAddr >= ptps_pkg::REG_QDATA
              && regAddr <= ptps_pkg::REG_QLAST
              && regAddr[1:0] == 2'h0 && level_r != '0) begin
            regRdata <= qWord;
          end else begin
            regRdata <= 32'h0000_0000;
          end
        end
      endcase
    end else begin
      regRdata <= 32'h0000_0000;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // The line input already comes out of the decryption stage.
  ptps_path #(.IS_TX(1'b0), .DLY(DLY)) u_rx (
    .clock,
    .resetn,
    .timeSec,
    .timeNs,
    .inData   (lineRxData),
    .inValid  (lineRxValid),
    .inLast   (lineRxLast),
    .enable   (ctrl_r[ptps_pkg::CTRL_RXEN]),
    .domain   (ctrl_r[7:0]),
    .tcMode   (1'b0),
    .lat      (rxLat_r),
    .asym     (asym_r),
    .idOff    (idOff_r),
    .outData  (sysRxData),
    .outValid (sysRxValid),
    .outLast  (sysRxLast),
    .save     (),
    .saveSec  (),
    .saveNs   (),
    .saveId   ()
  );

  ptps_path #(.IS_TX(1'b1), .DLY(DLY)) u_tx (
    .clock,
    .resetn,
    .timeSec,
    .timeNs,
    .inData   (sysTxData),
    .inValid  (sysTxValid),
    .inLast   (sysTxLast),
    .enable   (ctrl_r[ptps_pkg::CTRL_TXEN]),
    .domain   (ctrl_r[7:0]),
    .tcMode   (ctrl_r[ptps_pkg::CTRL_TC]),
    .lat      (txLat_r),
    .asym     (asym_r),
    .idOff    (idOff_r),
    .outData  (lineTxData),
    .outValid (lineTxValid),
    .outLast  (lineTxLast),
    .save     (txSave),
    .saveSec  (txSaveSec),
    .saveNs   (txSaveNs),
    .saveId   (txSaveId)
  );
endmodule : ptps_rewriter

////////////////////////////////////////////////////////////////////////////
module ptps_path #(
  parameter bit IS_TX = 1'b0,
  parameter int DLY   = 24
) (
  input  wire logic         clock,
  input  wire logic         resetn,
  input  wire logic [47:0]  timeSec,
  input  wire logic [29:0]  timeNs,
  input  wire logic [7:0]   inData,
  input  wire logic         inValid,
  input  wire logic         inLast,
  input  wire logic         enable,
  input  wire logic [7:0]   domain,
  input  wire logic         tcMode,
  input  wire logic [29:0]  lat,
  input  wire logic [31:0]  asym,
  input  wire logic [5:0]   idOff,
  output logic      [7:0]   outData,
  output logic              outValid,
  output logic              outLast,
  output logic              save,
  output logic      [47:0]  saveSec,
  output logic      [29:0]  saveNs,
  output logic      [127:0] saveId
);
  if (DLY < ptps_pkg::MIN_DLY) begin : g_bad_dly
    $error("DLY is too short for the header look-ahead.");
  end

  function automatic logic [31:0] crc8(logic [31:0] c, logic [7:0] b);
    logic [31:0] x;
    x = c ^ {24'h0, b};
    for (int i = 0; i < 8; i++) begin
      x = x[0] ? (x >> 1) ^ ptps_pkg::CRC_POLY : x >> 1;
    end
    return x;
  endfunction : crc8

  function automatic logic [15:0] oc(logic [15:0] a, logic [15:0] b);
    logic [16:0] s;
    s = {1'b0, a} + {1'b0, b};
    return s[15:0] + {15'h0, s[16]};
  endfunction : oc

  logic [7:0]         dData [DLY];
  logic [DLY-1:0]     dVal, dLast;
  logic               inBusy_r;
  logic [47:0]        stInSec_r, stSec_r;
  logic [29:0]        stInNs_r, stNs_r;
  logic [10:0]        headPos_r;
  ptps_pkg::ptps_kind_e kind_r, kindNow;
  logic [6:0]         base;
  logic [10:0]        off;
  logic               sof, inPtp, decNow, matchNow, actNow, tail;
  logic               inCorr, inResv, inOrig;
  logic               act_r, wrCorr_r, wrOrig_r, save_r;
  logic [3:0]         msg;
  logic [63:0]        corrOrig, corrNew, corrSh_r, asymX;
  logic [31:0]        resvOrig, resvSh_r;
  logic [79:0]        origSh_r;
  logic [29:0]        nsAdj, resid;
  logic [30:0]        nsSum;
  logic               secInc;
  logic [31:0]        origCrc_r, modCrc_r, newFcs, fcsSh_r;
  logic [15:0]        sumOld_r, sumNew_r, compNew, eth;
  logic [7:0]         compLo_r, outB;

  //////////////////////////////////////////////////////////////////////////
  always_ff @(posedge clock) begin
    for (int i = 0; i < DLY - 1; i++) begin
      dData[i] <= dData[i + 1];
    end
    dData[DLY-1] <= inData;
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      dVal  <= '0;
      dLast <= '0;
    end else begin
      dVal  <= {inValid, dVal[DLY-1:1]};
      dLast <= {inValid && inLast, dLast[DLY-1:1]};
    end
  end

  // The stamp moves on when its frame reaches the head, so frames may abut.
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      inBusy_r  <= 1'b0;
      stInSec_r <= '0;
      stInNs_r  <= '0;
      stSec_r   <= '0;
      stNs_r    <= '0;
    end else begin
      if (inValid) begin
        inBusy_r <= !inLast;
      end
      if (inValid && !inBusy_r) begin
        stInSec_r <= timeSec;
        stInNs_r  <= timeNs;
      end
      if (sof) begin
        stSec_r <= stInSec_r;
        stNs_r  <= stInNs_r;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  assign sof = dVal[0] && headPos_r == 11'd0;
  assign tail = |dLast[5:0];
  assign eth  = {dData[ptps_pkg::LA_ET], dData[ptps_pkg::LA_ET+1]};

  always_comb begin
    if (eth == ptps_pkg::ET_PTP) begin
      kindNow = ptps_pkg::KIND_L2;
    end else if (eth == ptps_pkg::ET_IP4
                 && dData[ptps_pkg::LA_IP4_PROT] == ptps_pkg::PROTO_UDP) begin
      kindNow = ptps_pkg::KIND_IP4;
    end else if (eth == ptps_pkg::ET_IP6
                 && dData[ptps_pkg::LA_IP6_NH] == ptps_pkg::PROTO_UDP) begin
      kindNow = ptps_pkg::KIND_IP6;
    end else begin
      kindNow = ptps_pkg::KIND_NONE;
    end
    case (kind_r)
      ptps_pkg::KIND_IP4: base = ptps_pkg::BASE_IP4;
      ptps_pkg::KIND_IP6: base = ptps_pkg::BASE_IP6;
      default:            base = ptps_pkg::BASE_L2;
    endcase
  end

  assign off   = headPos_r - {4'h0, base};
  assign inPtp = headPos_r >= {4'h0, base};
  assign inCorr = off - ptps_pkg::OFF_CORR < ptps_pkg::LEN_CORR;
  assign inResv = off - ptps_pkg::OFF_RESV < ptps_pkg::LEN_RESV;
  assign inOrig = off - ptps_pkg::OFF_ORIG < ptps_pkg::LEN_ORIG;
  // Deciding two bytes early leaves time to clear an IPv4 UDP checksum.
  assign decNow = dVal[0] && kind_r != ptps_pkg::KIND_NONE
                  && headPos_r == {4'h0, base} - 11'd2;
  assign msg      = dData[2][3:0];
  assign corrOrig = {dData[10], dData[11], dData[12], dData[13],
                     dData[14], dData[15], dData[16], dData[17]};
  assign resvOrig = {dData[18], dData[19], dData[20], dData[21]};
  // Only event messages match; Delay_resp passes.
  assign matchNow = enable && dData[6] == domain
                    && (msg == ptps_pkg::MSG_SYNC
                        || msg == ptps_pkg::MSG_DREQ);
  assign actNow = decNow ? matchNow : act_r;
  assign asymX  = {{32{asym[31]}}, asym};

  //////////////////////////////////////////////////////////////////////////
  always_comb begin
    nsSum  = {1'b0, stNs_r} + {1'b0, lat};
    secInc = 1'b0;
    resid  = '0;
    if (IS_TX) begin
      secInc = nsSum >= ptps_pkg::NS_PER_SEC;
      nsAdj  = secInc ? 30'(nsSum - ptps_pkg::NS_PER_SEC)
                      : nsSum[29:0];
      resid  = nsAdj >= resvOrig[29:0] ? nsAdj - resvOrig[29:0]
               : 30'(ptps_pkg::NS_PER_SEC + {1'b0, nsAdj}
                     - {1'b0, resvOrig[29:0]});
      if (tcMode && msg == ptps_pkg::MSG_DREQ) begin
        corrNew = {18'h0, resid, 16'h0} + asymX;
      end else if (msg == ptps_pkg::MSG_DREQ) begin
        corrNew = corrOrig + asymX;
      end else begin
        corrNew = corrOrig;
      end
    end else begin
      nsAdj = stNs_r >= lat ? stNs_r - lat
              : 30'(ptps_pkg::NS_PER_SEC + {1'b0, stNs_r} - {1'b0, lat});
      corrNew = msg == ptps_pkg::MSG_SYNC
                ? corrOrig + asymX : corrOrig;
    end
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      headPos_r <= '0;
      kind_r    <= ptps_pkg::KIND_NONE;
      act_r     <= 1'b0;
      wrCorr_r  <= 1'b0;
      wrOrig_r  <= 1'b0;
      save_r    <= 1'b0;
      saveSec   <= '0;
      saveNs    <= '0;
    end else begin
      if (dVal[0]) begin
        headPos_r <= dLast[0] ? 11'd0 : headPos_r + 11'd1;
      end
      if (sof) begin
        kind_r <= kindNow;
        act_r  <= 1'b0;
      end else if (decNow) begin
        act_r    <= matchNow;
        wrCorr_r <= IS_TX ? msg == ptps_pkg::MSG_DREQ
                          : msg == ptps_pkg::MSG_SYNC;
        wrOrig_r <= IS_TX && (msg == ptps_pkg::MSG_SYNC || !tcMode);
        save_r   <= IS_TX && msg == ptps_pkg::MSG_DREQ;
        saveSec  <= stSec_r + 48'(secInc);
        saveNs   <= nsAdj;
      end
    end
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      save   <= 1'b0;
      saveId <= '0;
    end else begin
      save <= dVal[0] && dLast[0] && act_r && save_r;
      if (dVal[0] && inPtp && off >= {5'h0, idOff}
          && off < {5'h0, idOff} + ptps_pkg::ID_BYTES) begin
        saveId <= {saveId[119:0], dData[0]};
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      corrSh_r <= '0;
      resvSh_r <= '0;
      origSh_r <= '0;
    end else if (decNow) begin
      corrSh_r <= corrNew;
      resvSh_r <= {2'h0, nsAdj};
      origSh_r <= {stSec_r + 48'(secInc), 2'h0, nsAdj};
    end else if (dVal[0] && inPtp) begin
      if (inCorr) begin
        corrSh_r <= corrSh_r << 8;
      end
      if (inResv) begin
        resvSh_r <= resvSh_r << 8;
      end
      if (inOrig) begin
        origSh_r <= origSh_r << 8;
      end
    end
  end

  // Compensation keeps the payload's one's-complement sum.
  assign compNew = oc(oc({dData[0], dData[1]}, sumOld_r), ~sumNew_r);
  assign newFcs  = ~modCrc_r ^ {32{{dData[3], dData[2], dData[1],
                   dData[0]} != ~origCrc_r}};

  always_comb begin
    outB = dData[0];
    if (actNow && inPtp) begin
      if (wrCorr_r && inCorr) begin
        outB = corrSh_r[63:56];
      end
      if (!IS_TX && inResv) begin
        outB = resvSh_r[31:24];
      end
      if (IS_TX && wrOrig_r && inOrig) begin
        outB = origSh_r[79:72];
      end
    end
    if (actNow && kind_r == ptps_pkg::KIND_IP4
        && (headPos_r == ptps_pkg::POS_UDP_CS
            || headPos_r == ptps_pkg::POS_UDP_CS + 11'd1)) begin
      outB = 8'h00;
    end
    if (act_r && kind_r == ptps_pkg::KIND_IP6) begin
      if (dLast[5]) begin
        outB = compNew[15:8];
      end else if (dLast[4]) begin
        outB = compLo_r;
      end
    end
    if (act_r && dLast[3]) begin
      outB = newFcs[7:0];
    end else if (act_r && |dLast[2:0]) begin
      outB = fcsSh_r[7:0];
    end
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      origCrc_r <= ptps_pkg::CRC_INIT;
      modCrc_r  <= ptps_pkg::CRC_INIT;
      fcsSh_r   <= '0;
      sumOld_r  <= '0;
      sumNew_r  <= '0;
      compLo_r  <= '0;
    end else if (dVal[0]) begin
      if (!(|dLast[3:0])) begin
        origCrc_r <= crc8(sof ? ptps_pkg::CRC_INIT : origCrc_r, dData[0]);
        modCrc_r  <= crc8(sof ? ptps_pkg::CRC_INIT : modCrc_r, outB);
      end
      fcsSh_r  <= dLast[3] ? newFcs >> 8 : fcsSh_r >> 8;
      compLo_r <= compNew[7:0];
      if (sof) begin
        sumOld_r <= '0;
        sumNew_r <= '0;
      end else if (inPtp && !tail) begin
        sumOld_r <= oc(sumOld_r, off[0] ? {8'h0, dData[0]}
                                        : {dData[0], 8'h0});
        sumNew_r <= oc(sumNew_r, off[0] ? {8'h0, outB} : {outB, 8'h0});
      end
    end
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      outData  <= '0;
      outValid <= 1'b0;
      outLast  <= 1'b0;
    end else begin
      outData  <= outB;
      outValid <= dVal[0];
      outLast  <= dLast[0];
    end
  end
endmodule : ptps_path

// File: verification/ptps_sva.sv
// Concurrent checks on the rewriter stream and register ports.
module ptps_sva #(
  parameter int DLY = 24
) (
  input wire logic        clock,
  input wire logic        resetn,
  input wire logic [7:0]  lineRxData,
  input wire logic        lineRxValid,
  input wire logic        lineRxLast,
  input wire logic [7:0]  sysRxData,
  input wire logic        sysRxValid,
  input wire logic        sysRxLast,
  input wire logic        sysTxValid,
  input wire logic        sysTxLast,
  input wire logic        lineTxValid,
  input wire logic        lineTxLast,
  input wire logic        regRd,
  input wire logic [31:0] regRdata
);
  localparam int LAT = DLY + 1;
  logic [4:0] pos_r;
  default clocking cb @(posedge clock); endclocking
  default disable iff (!resetn);
  // Saturates so a long frame cannot wrap into the header.
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn)
      pos_r <= 5'h00;
    else if (lineRxValid && lineRxLast)
      pos_r <= 5'h00;
    else if (lineRxValid && pos_r != 5'h1F)
      pos_r <= pos_r + 5'h01;
  end
  sequence hdr_s; lineRxValid && pos_r < 5'h0E; endsequence
  sequence same_s; sysRxData == $past(lineRxData, LAT); endsequence
  a_rx_hdr_kept: assert property (hdr_s |-> ##LAT same_s)
    else $error("header byte altered");
  a_rx_delay: assert property (lineRxValid |-> ##LAT sysRxValid)
    else $error("receive byte late");
  a_rx_idle: assert property (!lineRxValid |-> ##LAT !sysRxValid)
    else $error("receive byte invented");
  a_rx_last: assert property (lineRxLast |-> ##LAT sysRxLast)
    else $error("receive end lost");
  a_tx_delay: assert property (sysTxValid |-> ##LAT lineTxValid)
    else $error("transmit byte late");
  a_tx_idle: assert property (!sysTxValid |-> ##LAT !lineTxValid)
    else $error("transmit byte invented");
  a_tx_last: assert property (sysTxLast |-> ##LAT lineTxLast)
    else $error("transmit end lost");
  a_rd_quiet: assert property (
    !$past(regRd) |-> regRdata == 32'h0)
    else $error("read data outside its cycle");
endmodule : ptps_sva

// File: verification/ptps_peer.sv
// Byte stream source standing at either far side of the rewriter.
module ptps_peer (
  input  wire logic       clock,
  output logic      [7:0] data  = 8'h00,
  output logic            valid = 1'b0,
  output logic            last  = 1'b0
);
  timeunit 1ns;
  timeprecision 1ps;
  // Frames are whole and cleartext; valid stays high so frames abut.
  task automatic put(input logic [7:0] f[$]);
    for (int i = 0; i < f.size(); i++) begin
      data <= f[i];
      valid <= 1'b1;
      last <= (i == f.size() - 1);
      @(posedge clock);
    end
  endtask : put
  // A released line shows the inverse byte, never a stale copy.
  task automatic idle();
    data <= ~data;
    valid <= 1'b0;
    last <= 1'b0;
  endtask : idle
endmodule : ptps_peer

// File: verification/ptps_rewriter_test.sv
// Self-checking bench for the one-step stamp rewriter.
module ptps_rewriter_test;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int          DLY = 24;
  localparam logic [63:0] NS  = 64'(ptps_pkg::NS_PER_SEC);
  logic        clock = 1'b0, resetn = 1'b0, regWr = 1'b0, regRd = 1'b0;
  logic        rdPend = 1'b0;
  logic [63:0] tNow = 64'h12A05EA30;
  logic [7:0]  regAddr = 8'h00, dom, f[$], rxQ[$], txQ[$];
  logic [31:0] regWdata = 32'h0, regRdata, rxLat, txLat, qNs, rdQ[$];
  logic signed [31:0] asym;
  logic [7:0]  lineRxData, sysRxData, sysTxData, lineTxData;
  logic        lineRxValid, lineRxLast, sysRxValid, sysRxLast;
  logic        sysTxValid, sysTxLast, lineTxValid, lineTxLast;
  int          errorCnt = 0, testsRun = 0;
  wire logic [47:0] timeSec = 48'(tNow / NS);
  wire logic [29:0] timeNs  = 30'(tNow % NS);
  always #5 clock = ~clock;
  always @(posedge clock) tNow <= tNow + 64'hA;
  ptps_rewriter #(.DLY(DLY)) u_ptps_rewriter (.clock, .resetn, .timeSec,
    .timeNs, .lineRxData, .lineRxValid, .lineRxLast, .sysRxData, .sysRxValid,
    .sysRxLast, .sysTxData, .sysTxValid, .sysTxLast, .lineTxData,
    .lineTxValid, .lineTxLast, .regAddr, .regWdata, .regWr, .regRd,
    .regRdata);
  ptps_peer u_peer_line (.clock(clock), .data(lineRxData),
    .valid(lineRxValid), .last(lineRxLast));
  ptps_peer u_peer_sys (.clock(clock), .data(sysTxData),
    .valid(sysTxValid), .last(sysTxLast));
  task automatic check(input logic [31:0] seen, input logic [31:0] want);
    testsRun++;
    if (seen !== want) begin
      errorCnt++;
      $display("[FAIL] %0t seen %h want %h", $time, seen, want);
    end
  endtask : check
  always @(posedge clock) begin
    rdPend <= regRd;
    if (rdPend) check(regRdata, rdQ.pop_front());
    if (sysRxValid) check(32'(sysRxData), 32'(rxQ.pop_front()));
    if (lineTxValid) check(32'(lineTxData), 32'(txQ.pop_front()));
  end
  task automatic acc(input logic w, input logic [7:0] a, input logic [31:0] d);
    if (!w) rdQ.push_back(d);
    regWr <= w;
    regRd <= !w;
    regAddr <= a;
    regWdata <= d;
    @(posedge clock);
  endtask : acc
  function automatic void fcs(inout logic [7:0] g[$]);
    logic [31:0] c;
    c = ptps_pkg::CRC_INIT;
    foreach (g[i]) begin
      c ^= 32'(g[i]);
      for (int k = 0; k < 8; k++)
        c = c[0] ? (c >> 1) ^ ptps_pkg::CRC_POLY : c >> 1;
    end
    for (int k = 0; k < 4; k++) g.push_back(8'(~c >> (8 * k)));
  endfunction : fcs
  function automatic void mk(output logic [7:0] g[$], input logic [3:0] m,
                             input logic [7:0] d);
    g = {};
    for (int i = 0; i < 60; i++) g.push_back(8'($urandom));
    g[12] = 8'h88;
    g[13] = 8'hF7;
    g[14] = {4'h0, m};
    g[18] = d;
    for (int i = 22; i < 34; i++) g[i] = 8'h00;
    fcs(g);
  endfunction : mk
  function automatic void setb(inout logic [7:0] g[$], input int at,
                               input logic [79:0] v, input int n);
    for (int k = 0; k < n; k++) g[at + k] = v[8 * (n - 1 - k) +: 8];
  endfunction : setb
  // Queues the output expected for frame g stamped at t.
  function automatic void xp(ref logic [7:0] q[$], input logic [7:0] g[$],
                             input logic tx, input logic [63:0] t);
    logic [7:0]  e[$];
    logic [63:0] n;
    logic        bad;
    e = g[0:59];
    fcs(e);
    bad = e[63] !== g[63];
    e = g[0:59];
    if (g[14] < 8'h02 && g[18] == dom) begin
      n = t + (tx ? 64'(txLat) : NS - 64'(rxLat));
      if (tx) setb(e, 48, {48'(n / NS), 32'(n % NS)}, 10);
      else setb(e, 30, 80'(n % NS), 4);
      if (g[14] == {7'h0, tx}) setb(e, 22, 80'(64'(asym)), 8);
      if (tx && g[14] == 8'h01) qNs = 32'(n % NS);
      fcs(e);
      for (int k = 60; k < 64 && bad; k++) e[k] = ~e[k];
    end else e = g;
    foreach (e[i]) q.push_back(e[i]);
  endfunction : xp
  task automatic wrapUp();
    $display("comparisons %0d mismatches %0d", testsRun, errorCnt);
    if (errorCnt == 0 && testsRun > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : wrapUp
  // Tests need under 1000 cycles; 20000 means a hang.
  initial begin
    #200us;
    errorCnt++;
    wrapUp();
  end
  initial begin
    void'($urandom(35));
    repeat (8) @(posedge clock);
    resetn <= 1'b1;
    dom = 8'($urandom);
    rxLat = $urandom & 32'h3FF;
    txLat = $urandom & 32'h3FF;
    asym = $urandom;
    acc(1'b1, ptps_pkg::REG_CTRL, {24'h3, dom});
    acc(1'b1, ptps_pkg::REG_RX_LAT, rxLat);
    acc(1'b1, ptps_pkg::REG_TX_LAT, txLat);
    acc(1'b1, ptps_pkg::REG_ASYM, asym);
    acc(1'b0, ptps_pkg::REG_CTRL, {24'h3, dom});
    acc(1'b0, ptps_pkg::REG_ASYM, asym);
    acc(1'b0, 8'hFC, 32'h0);
    acc(1'b0, ptps_pkg::REG_QSTAT, 32'h0);
    regRd <= 1'b0;
    $display("register test done");
    for (int j = 0; j < 5; j++) begin
      mk(f, (j == 3) ? 4'h9 : 4'(j == 1), dom + 8'(j == 2));
      if (j == 4) f[63] = ~f[63];
      xp(rxQ, f, 1'b0, tNow + 64'hA);
      u_peer_line.put(f);
    end
    u_peer_line.idle();
    for (int j = 0; j < 2; j++) begin
      mk(f, 4'(j), dom);
      xp(txQ, f, 1'b1, tNow + 64'hA);
      u_peer_sys.put(f);
    end
    u_peer_sys.idle();
    repeat (DLY + 4) @(posedge clock);
    check(32'(rxQ.size() + txQ.size()), 32'h0);
    $display("stream test done");
    acc(1'b0, ptps_pkg::REG_QSTAT, 32'h1);
    acc(1'b0, ptps_pkg::REG_QDATA, qNs);
    acc(1'b1, ptps_pkg::REG_QSTAT, 32'h1);
    acc(1'b0, ptps_pkg::REG_QSTAT, 32'h0);
    regRd <= 1'b0;
    repeat (2) @(posedge clock);
    $display("queue test done");
    wrapUp();
  end
endmodule : ptps_rewriter_test
bind ptps_rewriter ptps_sva #(.DLY(DLY)) u_sva (.clock, .resetn, .lineRxData,
  .lineRxValid, .lineRxLast, .sysRxData, .sysRxValid, .sysRxLast,
  .sysTxValid, .sysTxLast, .lineTxValid, .lineTxLast, .regRd, .regRdata);
